// ### dv/codec_port_frame_config_test.sv
// Self-checking bench for the frame configuration register
`timescale 1ns/1ns
`include "cpfc_consts.vh"
module codec_port_frame_config_test;
	reg clk = 0, sys_rst = 1, wr_s = 0, rd_s = 0, en = 0;
	reg [15:0] adr = 0;
	reg [7:0] wd = 0, exp_r = 0;
	wire [7:0] rdat;
	wire [5:0] slots;
	wire [2:0] mode, lines;
	wire [1:0] n_out, n_in;
	wire m_gp, m_cs, m_ac, m_ac2, m_i2s;
	integer n_mismatch = 0, cmp_count = 0, seed = 38316, i;
	cpfc_top u_dut (.clk(clk), .sys_rst(sys_rst), .mcu_addr(adr), .mcu_wr(wr_s), .mcu_rd(rd_s), .mcu_wdata(wd),
		.mcu_rdata(rdat), .serial_port_global_enable(en), .frame_slot_count(slots), .port_mode(mode),
		.mode_general(m_gp), .mode_codec_specific_framing(m_cs), .mode_ac97(m_ac), .mode_ac97_v2(m_ac2),
		.mode_i2s(m_i2s), .i2s_data_out_count(n_out), .i2s_data_in_count(n_in));
	cpfc_codec u_codec (.n_out(n_out), .n_in(n_in), .n_lines(lines));
	initial forever #10 clk = ~clk;
	function [7:0] flags(input [2:0] c);
		flags = {c == 3'h0, c == 3'h1, c[2:1] == 2'h1, c == 3'h3, c >= 3'h4 && c <= 3'h6, 3'h0};
		if (flags[3]) flags[2:0] = 3'h4;
	endfunction
	function [7:0] cnts(input [2:0] c);
		cnts = (c >= 3'h4 && c <= 3'h6) ? {1'b0, 2'h3 - c[1:0], c[1:0] + 2'h1, c} : {5'h0, c};
	endfunction
	task chk(input [7:0] seen, input [7:0] want, input [47:0] what);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== want) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR %0s expected %h seen %h", what, want, seen);
			end
		end
	endtask
	task wr(input e, input [15:0] a, input [7:0] d);
		begin
			@(posedge clk) {wr_s, en, adr, wd} <= {1'b1, e, a, d};
			@(posedge clk) wr_s <= 0;
			if (!e && a == `CPFC_CFG1_ADDR) exp_r = d;
		end
	endtask
	task rd(input [15:0] a, input [7:0] want);
		begin
			@(posedge clk) {rd_s, adr} <= {1'b1, a};
			@(posedge clk) rd_s <= 0;
			@(negedge clk) chk(rdat, want, "rdata");
		end
	endtask
	task dec;
		begin
			chk({m_gp, m_cs, m_ac, m_ac2, m_i2s, lines}, flags(exp_r[2:0]), "flags");
			chk({1'b0, n_out, n_in, mode}, cnts(exp_r[2:0]), "counts");
			chk({2'h0, slots}, exp_r[7:3] + 8'h01, "slots");
		end
	endtask
	task conclude;
		begin
			$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
			if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
			else $display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		rd(`CPFC_CFG1_ADDR, 8'h00);
		dec;
		for (i = 0; i < 8; i = i + 1) begin
			wr(0, `CPFC_CFG1_ADDR, {5'h1f - i[4:0], i[2:0]});
			rd(`CPFC_CFG1_ADDR, exp_r);
			dec;
		end
		wr(1, `CPFC_CFG1_ADDR, ~exp_r);
		rd(`CPFC_CFG1_ADDR, exp_r);
		dec;
		rd(16'hffdf, 8'h00);
		for (i = 0; i < 60; i = i + 1) begin
			wr($random(seed) % 3 == 0, i % 5 == 0 ? 16'hffdf : `CPFC_CFG1_ADDR, 8'($random(seed)));
			rd(`CPFC_CFG1_ADDR, exp_r);
			dec;
		end
		wr(0, `CPFC_CFG1_ADDR, 8'hff);
		rd(`CPFC_CFG1_ADDR, 8'hff);
		@(posedge clk) {sys_rst, en} <= 2'b10;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		exp_r = 0;
		rd(`CPFC_CFG1_ADDR, 8'h00);
		dec;
		conclude;
	end
endmodule

// ### dv/cpfc_assertions.sv
// Port checker for the frame configuration register
`timescale 1ns/1ns
module cpfc_chk (
	input wire clk, input wire sys_rst, input wire [15:0] mcu_addr, input wire mcu_wr, input wire mcu_rd,
	input wire [7:0] mcu_wdata, input wire [7:0] mcu_rdata, input wire serial_port_global_enable,
	input wire [5:0] frame_slot_count, input wire [2:0] port_mode, input wire mode_i2s, input wire [1:0] i2s_data_out_count
);
	wire hit = mcu_addr == 16'hffe0;
	wire wok = mcu_wr && hit && !serial_port_global_enable;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_MODE: assert property (wok |-> ##2 port_mode == $past(mcu_wdata[2:0], 2)) else $error("mode");
	AST_SLOT: assert property (wok |-> ##2 frame_slot_count == $past(mcu_wdata[7:3], 2) + 6'h01) else $error("slots");
	AST_LOCK: assert property (mcu_wr && serial_port_global_enable |-> ##2 $stable(port_mode) && $stable(frame_slot_count)) else $error("lock");
	AST_RD: assert property (mcu_rd && hit |=> mcu_rdata == {frame_slot_count[4:0] - 5'h01, port_mode}) else $error("rd");
	AST_IDLE: assert property (!(mcu_rd && hit) |=> mcu_rdata == 8'h00) else $error("idle");
	AST_I2S: assert property (mode_i2s == (port_mode inside {3'h4, 3'h5, 3'h6})) else $error("i2s");
	AST_OUT: assert property (i2s_data_out_count == (mode_i2s ? 2'h3 - port_mode[1:0] : 2'h0)) else $error("outs");
	AST_RST: assert property ($past(sys_rst) |-> frame_slot_count == 6'h01 && port_mode == 3'h0) else $error("rst");
	cover property (wok);
	cover property (mcu_wr && serial_port_global_enable);
	cover property (mcu_rd && hit);
	cover property (mode_i2s);
endmodule
bind cpfc_top cpfc_chk u_chk (.clk, .sys_rst, .mcu_addr, .mcu_wr, .mcu_rd, .mcu_wdata, .mcu_rdata,
	.serial_port_global_enable, .frame_slot_count, .port_mode, .mode_i2s, .i2s_data_out_count);

// ### dv/cpfc_codec.sv
// Codec side model
`timescale 1ns/1ns
module cpfc_codec (
	input wire [1:0] n_out,
	input wire [1:0] n_in,
	output wire [2:0] n_lines
);
	// Every I2S mode spends four data lines
	assign n_lines = n_out + n_in;
endmodule

// ### hdl/cpfc_consts.vh
// Constants for the codec port frame configuration block
`ifndef CPFC_CONSTS_VH
`define CPFC_CONSTS_VH

// ==========================================
// Register map
`define CPFC_ADDR_W 16
`define CPFC_CFG1_ADDR 16'hffe0
`define CPFC_CFG1_RESET 8'h00

// ==========================================
// Field layout
`define CPFC_SLOT_HI 7
`define CPFC_SLOT_LO 3
`define CPFC_MODE_HI 2
`define CPFC_MODE_LO 0

// ==========================================
// Mode codes
`define CPFC_MODE_GP 3'h0
`define CPFC_MODE_CODEC 3'h1
`define CPFC_MODE_AC97_1 3'h2
`define CPFC_MODE_AC97_2 3'h3
`define CPFC_MODE_I2S_3O1I 3'h4
`define CPFC_MODE_I2S_2O2I 3'h5
`define CPFC_MODE_I2S_1O3I 3'h6

// ==========================================
// Misc
`define CPFC_RD_ZERO 8'h00
`define CPFC_SLOT_ONE 6'h01

`endif

// ### hdl/cpfc_top.v
// Codec port frame configuration register and mode decode
`timescale 1ns/1ns
`include "cpfc_consts.vh"

module cpfc_top (
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Microcontroller memory bus
	input wire [`CPFC_ADDR_W-1:0] mcu_addr,
	input wire mcu_wr,
	input wire mcu_rd,
	input wire [7:0] mcu_wdata,
	output reg [7:0] mcu_rdata,
	// Global control
	input wire serial_port_global_enable,
	// Decoded configuration toward the serial engine
	output reg [5:0] frame_slot_count,
	output reg [2:0] port_mode,
	output reg mode_general,
	output reg mode_codec_specific_framing,
	output reg mode_ac97,
	output reg mode_ac97_v2,
	output reg mode_i2s,
	output reg [1:0] i2s_data_out_count,
	output reg [1:0] i2s_data_in_count
);

	// ==========================================
	// Register storage
	reg [7:0] codec_port_frame_config_one_r;
	reg [7:0] cfg_nxt;
	wire cfg_hit;
	wire [4:0] slot_count_field;
	wire [2:0] mode_field;

	wire wr_hit;
	wire wr_accept;
	wire rd_hit;

	assign cfg_hit = (mcu_addr == `CPFC_CFG1_ADDR);
	assign slot_count_field = codec_port_frame_config_one_r[`CPFC_SLOT_HI:`CPFC_SLOT_LO];
	assign mode_field = codec_port_frame_config_one_r[`CPFC_MODE_HI:`CPFC_MODE_LO];
	assign wr_hit = mcu_wr && cfg_hit;
	// Enable is a level; a write landing while it is high is lost, not queued
	assign wr_accept = wr_hit && !serial_port_global_enable;
	assign rd_hit = mcu_rd && cfg_hit;

	// Locked write simply falls through
	always @* begin
		cfg_nxt = codec_port_frame_config_one_r;
		if (wr_accept) begin
			cfg_nxt = mcu_wdata;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			codec_port_frame_config_one_r <= `CPFC_CFG1_RESET;
		end else begin
			codec_port_frame_config_one_r <= cfg_nxt;
		end
	end

	// ==========================================
	// Read port, one cycle latency; other addresses read zero
	reg [7:0] rdata_nxt;

	always @* begin
		rdata_nxt = `CPFC_RD_ZERO;
		if (rd_hit) begin
			rdata_nxt = codec_port_frame_config_one_r;
		end
	end

	// Zero when idle so a wired-OR read mux above needs no select
	always @(posedge clk) begin
		if (sys_rst) begin
			mcu_rdata <= `CPFC_RD_ZERO;
		end else begin
			mcu_rdata <= rdata_nxt;
		end
	end

	// ==========================================
	// Slot count, field plus one
	reg [5:0] slot_count_nxt;

	always @* begin
		slot_count_nxt = {1'b0, slot_count_field} + `CPFC_SLOT_ONE;
	end

	// ==========================================
	// Mode decode, one full row per code
	reg mode_general_nxt;
	reg mode_codec_nxt;
	reg mode_ac97_nxt;
	reg mode_ac97_v2_nxt;
	reg mode_i2s_nxt;
	reg [1:0] i2s_out_nxt;
	reg [1:0] i2s_in_nxt;

	always @* begin
		case (mode_field)
			`CPFC_MODE_GP: begin
				mode_general_nxt = 1'b1;
				mode_codec_nxt = 1'b0;
				mode_ac97_nxt = 1'b0;
				mode_ac97_v2_nxt = 1'b0;
				mode_i2s_nxt = 1'b0;
				i2s_out_nxt = 2'h0;
				i2s_in_nxt = 2'h0;
			end
			`CPFC_MODE_CODEC: begin
				mode_general_nxt = 1'b0;
				mode_codec_nxt = 1'b1;
				mode_ac97_nxt = 1'b0;
				mode_ac97_v2_nxt = 1'b0;
				mode_i2s_nxt = 1'b0;
				i2s_out_nxt = 2'h0;
				i2s_in_nxt = 2'h0;
			end
			`CPFC_MODE_AC97_1: begin
				mode_general_nxt = 1'b0;
				mode_codec_nxt = 1'b0;
				mode_ac97_nxt = 1'b1;
				mode_ac97_v2_nxt = 1'b0;
				mode_i2s_nxt = 1'b0;
				i2s_out_nxt = 2'h0;
				i2s_in_nxt = 2'h0;
			end
			// Version 2 still runs the common AC 97 framing
			`CPFC_MODE_AC97_2: begin
				mode_general_nxt = 1'b0;
				mode_codec_nxt = 1'b0;
				mode_ac97_nxt = 1'b1;
				mode_ac97_v2_nxt = 1'b1;
				mode_i2s_nxt = 1'b0;
				i2s_out_nxt = 2'h0;
				i2s_in_nxt = 2'h0;
			end
			// Four data lines shared out in each I2S row
			`CPFC_MODE_I2S_3O1I: begin
				mode_general_nxt = 1'b0;
				mode_codec_nxt = 1'b0;
				mode_ac97_nxt = 1'b0;
				mode_ac97_v2_nxt = 1'b0;
				mode_i2s_nxt = 1'b1;
				i2s_out_nxt = 2'h3;
				i2s_in_nxt = 2'h1;
			end
			`CPFC_MODE_I2S_2O2I: begin
				mode_general_nxt = 1'b0;
				mode_codec_nxt = 1'b0;
				mode_ac97_nxt = 1'b0;
				mode_ac97_v2_nxt = 1'b0;
				mode_i2s_nxt = 1'b1;
				i2s_out_nxt = 2'h2;
				i2s_in_nxt = 2'h2;
			end
			`CPFC_MODE_I2S_1O3I: begin
				mode_general_nxt = 1'b0;
				mode_codec_nxt = 1'b0;
				mode_ac97_nxt = 1'b0;
				mode_ac97_v2_nxt = 1'b0;
				mode_i2s_nxt = 1'b1;
				i2s_out_nxt = 2'h1;
				i2s_in_nxt = 2'h3;
			end
			default: begin
				// Code 7 undefined: no flag, so the engine stays idle
				mode_general_nxt = 1'b0;
				mode_codec_nxt = 1'b0;
				mode_ac97_nxt = 1'b0;
				mode_ac97_v2_nxt = 1'b0;
				mode_i2s_nxt = 1'b0;
				i2s_out_nxt = 2'h0;
				i2s_in_nxt = 2'h0;
			end
		endcase
	end

	// ==========================================
	// Output stage; costs one cycle but keeps every pin on a flop
	always @(posedge clk) begin
		if (sys_rst) begin
			frame_slot_count <= `CPFC_SLOT_ONE;
			port_mode <= `CPFC_MODE_GP;
		end else begin
			frame_slot_count <= slot_count_nxt;
			port_mode <= mode_field;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			mode_general <= 1'b1;
			mode_codec_specific_framing <= 1'b0;
			mode_ac97 <= 1'b0;
			mode_ac97_v2 <= 1'b0;
			mode_i2s <= 1'b0;
			i2s_data_out_count <= 2'h0;
			i2s_data_in_count <= 2'h0;
		end else begin
			mode_general <= mode_general_nxt;
			mode_codec_specific_framing <= mode_codec_nxt;
			mode_ac97 <= mode_ac97_nxt;
			mode_ac97_v2 <= mode_ac97_v2_nxt;
			mode_i2s <= mode_i2s_nxt;
			i2s_data_out_count <= i2s_out_nxt;
			i2s_data_in_count <= i2s_in_nxt;
		end
	end

endmodule
